// >>> inc/ffp_params.svh
/*
 Timing counts, command codes and unlock addresses for the flash command host.
 Assumes a 10 MHz core clock and a 16-bit flash bus.
*/
`ifndef FFP_PARAMS_SVH
`define FFP_PARAMS_SVH
`define FFP_CLK_NS        100
`define FFP_WE_LOW_NS     100
`define FFP_WE_HIGH_NS    100
`define FFP_WE_LOW_CYC    ((`FFP_WE_LOW_NS + `FFP_CLK_NS - 1) / `FFP_CLK_NS)
`define FFP_WE_HIGH_CYC   ((`FFP_WE_HIGH_NS + `FFP_CLK_NS - 1) / `FFP_CLK_NS)
`define FFP_ADDR_UNLOCK1  23'h000555
`define FFP_ADDR_UNLOCK2  23'h0002aa
`define FFP_DATA_UNLOCK1  16'h00aa
`define FFP_DATA_UNLOCK2  16'h0055
`define FFP_CMD_WBUF      16'h0025
`define FFP_CMD_CONFIRM   16'h0029
`define FFP_CMD_ABORT     16'h00f0
`define FFP_CMD_BYPASS    16'h0020
`define FFP_CMD_BP_PROG   16'h00a0
`define FFP_CMD_ERASE     16'h0080
`define FFP_CMD_BLK_ERASE 16'h0030
`define FFP_CMD_CHIP_ERASE 16'h0010
`define FFP_CMD_BP_RESET1 16'h0090
`define FFP_CMD_BP_RESET2 16'h0000
`define FFP_CMD_EBUF      16'h0033
`define FFP_CMD_EXT_ENTRY 16'h0088
`define FFP_CMD_EXT_EXIT3 16'h0090
`define FFP_CMD_EXT_EXIT4 16'h0000
`define FFP_WBUF_MAX_CNT  5'h1f
`define FFP_EBUF_WORDS    9'h100
`define FFP_PAGE_LSB      5
`endif

// >>> inc/ffp_pkg.sv
/*
 Types for the flash command host.
 Assumes the params header is included by users of these types.
*/
package ffp_pkg;
  typedef enum logic [3:0] {
    FFP_OP_WBUF,
    FFP_OP_ABORT,
    FFP_OP_BYPASS_ENTER,
    FFP_OP_BYPASS_PROG,
    FFP_OP_BYPASS_BLK_ERASE,
    FFP_OP_BYPASS_CHIP_ERASE,
    FFP_OP_BYPASS_RESET,
    FFP_OP_EBUF,
    FFP_OP_EXT_ENTER,
    FFP_OP_EXT_EXIT,
    FFP_OP_READ
  } ffp_op_t;
endpackage

// >>> inc/ffp_wr_if.sv
/*
 Bus-cycle request channel between the sequencer and the pin driver.
 Assumes both ends run on one clock.
*/
`timescale 1ns/100ps
interface ffp_wr_if;
  logic        req;
  logic        rd;
  logic [22:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport seq (output req, output rd, output addr, output wdata, input done, input rdata);
  modport drv (input req, input rd, input addr, input wdata, output done, output rdata);
endinterface

// >>> core/ffp_pin_drv.sv
/*
 Drives one flash bus cycle (write or read) on the strobe pins per request.
 Assumes the flash pins are idle-high strobes and data is sampled via two flops.
*/
`timescale 1ns/100ps
`include "ffp_params.svh"
module ffp_pin_drv (
  input  wire logic core_clk,
  input  wire logic srst,
  ffp_wr_if.drv     bus,
  input  wire logic [15:0] dq_sync,
  output logic      [22:0] pin_addr,
  output logic      [15:0] pin_dq_out,
  output logic             pin_dq_oe,
  output logic             pin_ce_n,
  output logic             pin_we_n,
  output logic             pin_oe_n
);
  localparam logic [3:0] LOW_CYC  = 4'(`FFP_WE_LOW_CYC);
  localparam logic [3:0] HIGH_CYC = 4'(`FFP_WE_HIGH_CYC + 2);
  typedef enum logic [1:0] {ffp_idle_t_i, ffp_low_t_i, ffp_high_t_i} ffp_pstate_t;
  ffp_pstate_t st, next_st;
  logic [3:0]  cnt, next_cnt;
  logic [22:0] next_addr;
  logic [15:0] next_dq, next_rdata;
  logic        next_oe, next_ce_n, next_we_n, next_oe_n, next_done, is_rd, next_is_rd;
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_addr = pin_addr;
    next_dq = pin_dq_out;
    next_oe = pin_dq_oe;
    next_ce_n = pin_ce_n;
    next_we_n = pin_we_n;
    next_oe_n = pin_oe_n;
    next_done = 1'b0;
    next_rdata = bus.rdata;
    next_is_rd = is_rd;
    case (st)
      ffp_idle_t_i: begin
        if (bus.req) begin
          next_addr = bus.addr;
          next_dq = bus.wdata;
          next_oe = !bus.rd;
          next_ce_n = 1'b0;
          next_we_n = bus.rd;
          next_oe_n = !bus.rd;
          next_is_rd = bus.rd;
          next_cnt = bus.rd ? HIGH_CYC : LOW_CYC;
          next_st = ffp_low_t_i;
        end
      end
      ffp_low_t_i: begin
        if (cnt > 4'h1) begin
          next_cnt = cnt - 4'h1;
        end else begin
          // Write latched on rising strobe
          if (is_rd) begin
            next_rdata = dq_sync;
          end
          next_we_n = 1'b1;
          next_oe_n = 1'b1;
          next_ce_n = 1'b1;
          next_cnt = HIGH_CYC;
          next_st = ffp_high_t_i;
        end
      end
      default: begin
        if (cnt > 4'h1) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_oe = 1'b0;
          next_done = 1'b1;
          next_st = ffp_idle_t_i;
        end
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= ffp_idle_t_i;
      cnt <= 4'h0;
      pin_addr <= 23'h000000;
      pin_dq_out <= 16'h0000;
      pin_dq_oe <= 1'b0;
      pin_ce_n <= 1'b1;
      pin_we_n <= 1'b1;
      pin_oe_n <= 1'b1;
      bus.done <= 1'b0;
      bus.rdata <= 16'h0000;
      is_rd <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      pin_addr <= next_addr;
      pin_dq_out <= next_dq;
      pin_dq_oe <= next_oe;
      pin_ce_n <= next_ce_n;
      pin_we_n <= next_we_n;
      pin_oe_n <= next_oe_n;
      bus.done <= next_done;
      bus.rdata <= next_rdata;
      is_rd <= next_is_rd;
    end
  end
endmodule

// >>> core/ffp_host.sv
/*
 Host sequencer issuing fast-program, unlock-bypass, enhanced-buffer and
 extended-block command sequences to a 16-bit asynchronous NOR flash.
 Assumes buffer data arrive on a word stream with valid/ready from same-clock logic.
*/
`timescale 1ns/100ps
`include "ffp_params.svh"
module ffp_host #(
  parameter int EBUF_WORDS = 256
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             cmd_valid,
  input  wire ffp_pkg::ffp_op_t cmd_op,
  input  wire logic [22:0]      cmd_addr,
  input  wire logic [15:0]      cmd_data,
  input  wire logic [4:0]       cmd_count,
  output logic                  cmd_ready,
  input  wire logic             wd_valid,
  input  wire logic [15:0]      wd_data,
  output logic                  wd_ready,
  output logic                  cmd_done,
  output logic                  cmd_error,
  output logic [15:0]           rd_data,
  output logic                  bypass_mode,
  output logic                  ext_mode,
  output logic [22:0]           flash_addr,
  output logic [15:0]           flash_dq_out,
  output logic                  flash_dq_oe,
  input  wire logic [15:0]      flash_dq_in,
  output logic                  flash_ce_n,
  output logic                  flash_we_n,
  output logic                  flash_oe_n
);
  typedef enum logic [2:0] {ffp_idle_t_s, ffp_issue_t_s, ffp_wait_t_s, ffp_fin_t_s} ffp_state_t;
  ffp_wr_if    wr ();
  ffp_state_t  st, next_st;
  ffp_pkg::ffp_op_t op, next_op;
  logic [9:0]  step, next_step;
  logic [22:0] base, next_base;
  logic [15:0] data, next_data;
  logic [4:0]  count, next_count;
  logic        next_bypass, next_ext, next_done, next_err, next_cready, next_wready;
  logic [15:0] next_rd;
  logic [15:0] dq_meta, dq_sync;
  logic        req, next_req, rd, next_rdreq;
  logic [22:0] waddr, next_waddr;
  logic [15:0] wdat, next_wdat;
  logic        last, is_load;

  // Address in the page that holds a, with the word offset replaced by off
  function automatic logic [22:0] page_addr(input logic [22:0] a, input logic [4:0] off);
    page_addr = {a[22:`FFP_PAGE_LSB], off};
  endfunction

  assign wr.req   = req;
  assign wr.rd    = rd;
  assign wr.addr  = waddr;
  assign wr.wdata = wdat;

  ffp_pin_drv u_drv (
    .core_clk   (core_clk),
    .srst       (srst),
    .bus        (wr),
    .dq_sync    (dq_sync),
    .pin_addr   (flash_addr),
    .pin_dq_out (flash_dq_out),
    .pin_dq_oe  (flash_dq_oe),
    .pin_ce_n   (flash_ce_n),
    .pin_we_n   (flash_we_n),
    .pin_oe_n   (flash_oe_n)
  );

  // Bus cycle number step of the current sequence
  always_comb begin
    next_waddr = base;
    next_wdat  = data;
    next_rdreq = 1'b0;
    last       = 1'b0;
    is_load    = 1'b0;
    case (op)
      ffp_pkg::FFP_OP_ABORT, ffp_pkg::FFP_OP_BYPASS_ENTER, ffp_pkg::FFP_OP_EXT_ENTER,
      ffp_pkg::FFP_OP_EXT_EXIT: begin
        next_waddr = (step == 10'h1) ? `FFP_ADDR_UNLOCK2 : `FFP_ADDR_UNLOCK1;
        next_wdat  = (step == 10'h0) ? `FFP_DATA_UNLOCK1 : (step == 10'h1) ? `FFP_DATA_UNLOCK2 :
                     (op == ffp_pkg::FFP_OP_ABORT) ? `FFP_CMD_ABORT :
                     (op == ffp_pkg::FFP_OP_BYPASS_ENTER) ? `FFP_CMD_BYPASS :
                     (op == ffp_pkg::FFP_OP_EXT_ENTER) ? `FFP_CMD_EXT_ENTRY :
                     (step == 10'h2) ? `FFP_CMD_EXT_EXIT3 : `FFP_CMD_EXT_EXIT4;
        last = (op == ffp_pkg::FFP_OP_EXT_EXIT) ? (step == 10'h3) : (step == 10'h2);
      end
      ffp_pkg::FFP_OP_BYPASS_PROG: begin
        next_wdat = (step == 10'h0) ? `FFP_CMD_BP_PROG : data;
        last = (step == 10'h1);
      end
      ffp_pkg::FFP_OP_BYPASS_BLK_ERASE, ffp_pkg::FFP_OP_BYPASS_CHIP_ERASE: begin
        next_wdat = (step == 10'h0) ? `FFP_CMD_ERASE :
                    (op == ffp_pkg::FFP_OP_BYPASS_CHIP_ERASE) ? `FFP_CMD_CHIP_ERASE : `FFP_CMD_BLK_ERASE;
        last = (step == 10'h1);
      end
      ffp_pkg::FFP_OP_BYPASS_RESET: begin
        next_wdat = (step == 10'h0) ? `FFP_CMD_BP_RESET1 : `FFP_CMD_BP_RESET2;
        last = (step == 10'h1);
      end
      ffp_pkg::FFP_OP_WBUF: begin
        if (!bypass_mode && step < 10'h2) begin
          next_waddr = (step == 10'h1) ? `FFP_ADDR_UNLOCK2 : `FFP_ADDR_UNLOCK1;
          next_wdat  = (step == 10'h0) ? `FFP_DATA_UNLOCK1 : `FFP_DATA_UNLOCK2;
        end else if (step == (bypass_mode ? 10'h0 : 10'h2)) begin
          next_wdat = `FFP_CMD_WBUF;
        end else if (step == (bypass_mode ? 10'h1 : 10'h3)) begin
          next_wdat = {11'h000, count};
        end else if (step == (bypass_mode ? 10'h0 : 10'h2) + 10'h3 + {5'h00, count}) begin
          next_wdat = `FFP_CMD_CONFIRM;
          last = 1'b1;
        end else begin
          is_load = 1'b1;
          next_waddr = page_addr(base, base[4:0] + 5'(step - (bypass_mode ? 10'h2 : 10'h4)));
          next_wdat = wd_data;
        end
      end
      ffp_pkg::FFP_OP_EBUF: begin
        if (!bypass_mode && step < 10'h2) begin
          next_waddr = (step == 10'h1) ? `FFP_ADDR_UNLOCK2 : `FFP_ADDR_UNLOCK1;
          next_wdat  = (step == 10'h0) ? `FFP_DATA_UNLOCK1 : `FFP_DATA_UNLOCK2;
        end else if (step == (bypass_mode ? 10'h0 : 10'h2)) begin
          next_wdat = `FFP_CMD_EBUF;
        end else if (step == (bypass_mode ? 10'h1 : 10'h3) + 10'(EBUF_WORDS)) begin
          next_waddr = {base[22:8], 8'h00};
          next_wdat = `FFP_CMD_CONFIRM;
          last = 1'b1;
        end else begin
          is_load = 1'b1;
          next_waddr = {base[22:8], 8'(step - (bypass_mode ? 10'h1 : 10'h3))};
          next_wdat = wd_data;
        end
      end
      default: begin
        next_rdreq = 1'b1;
        last = 1'b1;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    next_op = op;
    next_step = step;
    next_base = base;
    next_data = data;
    next_count = count;
    next_bypass = bypass_mode;
    next_ext = ext_mode;
    next_done = 1'b0;
    next_err = 1'b0;
    next_rd = rd_data;
    next_req = 1'b0;
    next_cready = 1'b0;
    next_wready = 1'b0;
    case (st)
      ffp_idle_t_s: begin
        next_cready = 1'b1;
        if (cmd_valid && cmd_ready) begin
          next_cready = 1'b0;
          next_op = cmd_op;
          next_base = cmd_addr;
          next_data = cmd_data;
          next_count = cmd_count;
          next_step = 10'h0;
          next_st = ffp_issue_t_s;
          if ((ext_mode && (cmd_op == ffp_pkg::FFP_OP_BYPASS_BLK_ERASE ||
               cmd_op == ffp_pkg::FFP_OP_BYPASS_CHIP_ERASE || cmd_op == ffp_pkg::FFP_OP_BYPASS_ENTER)) ||
              // Bypass-only commands need bypass mode
              (!bypass_mode && (cmd_op == ffp_pkg::FFP_OP_BYPASS_PROG || cmd_op == ffp_pkg::FFP_OP_BYPASS_RESET ||
               cmd_op == ffp_pkg::FFP_OP_BYPASS_BLK_ERASE || cmd_op == ffp_pkg::FFP_OP_BYPASS_CHIP_ERASE)) ||
              (cmd_op == ffp_pkg::FFP_OP_WBUF && ({1'b0, cmd_addr[4:0]} + {1'b0, cmd_count}) > 6'h1f)) begin
            next_err = 1'b1;
            next_done = 1'b1;
            next_st = ffp_fin_t_s;
          end
        end
      end
      ffp_issue_t_s: begin
        if (!is_load || wd_valid) begin
          next_req = 1'b1;
          next_wready = is_load;
          next_st = ffp_wait_t_s;
        end
      end
      ffp_wait_t_s: begin
        if (wr.done) begin
          if (last) begin
            next_rd = wr.rdata;
            next_done = 1'b1;
            next_st = ffp_fin_t_s;
            if (op == ffp_pkg::FFP_OP_BYPASS_ENTER) next_bypass = 1'b1;
            if (op == ffp_pkg::FFP_OP_BYPASS_RESET) next_bypass = 1'b0;
            if (op == ffp_pkg::FFP_OP_EXT_ENTER) next_ext = 1'b1;
            if (op == ffp_pkg::FFP_OP_EXT_EXIT) next_ext = 1'b0;
          end else begin
            next_step = step + 10'h1;
            next_st = ffp_issue_t_s;
          end
        end
      end
      default: begin
        next_st = ffp_idle_t_s;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= ffp_idle_t_s;
      op <= ffp_pkg::FFP_OP_READ;
      step <= 10'h000;
      base <= 23'h000000;
      data <= 16'h0000;
      count <= 5'h00;
      bypass_mode <= 1'b0;
      ext_mode <= 1'b0;
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
      rd_data <= 16'h0000;
      req <= 1'b0;
      rd <= 1'b0;
      waddr <= 23'h000000;
      wdat <= 16'h0000;
      cmd_ready <= 1'b0;
      wd_ready <= 1'b0;
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
    end else begin
      st <= next_st;
      op <= next_op;
      step <= next_step;
      base <= next_base;
      data <= next_data;
      count <= next_count;
      bypass_mode <= next_bypass;
      ext_mode <= next_ext;
      cmd_done <= next_done;
      cmd_error <= next_err;
      rd_data <= next_rd;
      req <= next_req;
      if (next_req) begin
        rd <= next_rdreq;
        waddr <= next_waddr;
        wdat <= next_wdat;
      end
      cmd_ready <= next_cready;
      wd_ready <= next_wready;
      dq_meta <= flash_dq_in;
      dq_sync <= dq_meta;
    end
  end
endmodule

// >>> verification/ffp_flash_model.sv
/*
 Behavioural 16-bit flash: logs every bus write, tracks bypass and extended modes.
 Assumes writes complete on the rising write strobe; no hardware reset pin.
*/
`timescale 1ns/100ps
module ffp_flash_model (
  input  wire logic [22:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_dq_oe,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  output logic      [15:0] flash_dq_in
);
  logic [22:0] la[$];
  logic [15:0] ld[$];
  logic        byp = 1'b0;
  logic        ext = 1'b0;
  logic [15:0] rv;
  logic [15:0] lastv = 16'h0000;
  logic        unl;
  int          n;
  function automatic bit wr(input int k, input logic [22:0] a, input logic [15:0] d);
    return la[n - k] == a && ld[n - k] == d;
  endfunction
  assign rv = (ext && flash_addr[22:16] == 7'h00) ? {9'h000, flash_addr[6:0]} ^ 16'hc3c3 : flash_addr[15:0] ^ 16'h5a5a;
  // Array data only, busy status not modelled
  // Released bus shows inverse of last read
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : (!flash_ce_n && !flash_oe_n) ? rv : ~lastv;
  always @(posedge flash_oe_n) lastv = rv;
  always @(posedge flash_we_n) begin
    la.push_back(flash_addr);
    ld.push_back(flash_dq_in);
    n = la.size();
    unl = n > 2 && wr(3, 23'h555, 16'haa) && wr(2, 23'h2aa, 16'h55);
    // Bypass entry, not in extended mode
    if (unl && wr(1, 23'h555, 16'h20) && !ext) byp = 1'b1;
    // Only 90 then 00 leaves bypass
    if (byp && n > 1 && ld[n - 2] == 16'h90 && ld[n - 1] == 16'h00) byp = 1'b0;
    if (unl && wr(1, 23'h555, 16'h88)) ext = 1'b1;
    if (ext && n > 3 && wr(4, 23'h555, 16'haa) && wr(3, 23'h2aa, 16'h55) && wr(2, 23'h555, 16'h90) && ld[n - 1] == 16'h00)
      ext = 1'b0;
  end
endmodule

// >>> verification/ffp_host_checker.sv
/*
 Concurrent checks on the flash command host ports.
 Assumes one clock domain and bind onto ffp_host.
*/
`timescale 1ns/100ps
module ffp_host_checker #(
  parameter int EBUF_WORDS = 256
) (
  input wire logic             core_clk,
  input wire logic             srst,
  input wire logic             cmd_valid,
  input wire ffp_pkg::ffp_op_t cmd_op,
  input wire logic [22:0]      cmd_addr,
  input wire logic [4:0]       cmd_count,
  input wire logic             cmd_ready,
  input wire logic             cmd_done,
  input wire logic             cmd_error,
  input wire logic             bypass_mode,
  input wire logic             ext_mode,
  input wire logic             flash_dq_oe,
  input wire logic             flash_ce_n,
  input wire logic             flash_we_n,
  input wire logic             flash_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic             acc;
  ffp_pkg::ffp_op_t last_op;
  ffp_pkg::ffp_op_t next_last_op;
  assign acc = cmd_valid && cmd_ready;
  always_comb next_last_op = acc ? cmd_op : last_op;
  always_ff @(posedge core_clk) last_op <= next_last_op;
  AST_RESET_IDLE: assert property (disable iff (1'b0) srst |=> flash_we_n && flash_ce_n && flash_oe_n
    && !flash_dq_oe && !bypass_mode && !ext_mode && !cmd_ready) else $error("outputs not idle after reset");
  AST_REFUSE_PROG: assert property (acc && cmd_op == ffp_pkg::FFP_OP_BYPASS_PROG && !bypass_mode
    |=> cmd_done && cmd_error && flash_we_n) else $error("bypass program not refused");
  AST_REFUSE_SPAN: assert property (acc && cmd_op == ffp_pkg::FFP_OP_WBUF
    && {1'b0, cmd_addr[4:0]} + {1'b0, cmd_count} > 6'd31 |=> cmd_done && cmd_error) else $error("page overrun taken");
  AST_EXT_REFUSE: assert property (acc && ext_mode && cmd_op inside {ffp_pkg::FFP_OP_BYPASS_ENTER,
    ffp_pkg::FFP_OP_BYPASS_BLK_ERASE, ffp_pkg::FFP_OP_BYPASS_CHIP_ERASE} |=> cmd_error) else $error("ext refusal missing");
  AST_BYPASS_SET: assert property ($rose(bypass_mode) |-> last_op == ffp_pkg::FFP_OP_BYPASS_ENTER)
    else $error("bypass set without entry");
  AST_BYPASS_HOLD: assert property ($fell(bypass_mode) |-> last_op == ffp_pkg::FFP_OP_BYPASS_RESET
    || $past(srst)) else $error("bypass left early");
  AST_EXT_SET: assert property ($rose(ext_mode) |-> last_op == ffp_pkg::FFP_OP_EXT_ENTER)
    else $error("ext set without entry");
  AST_EXT_HOLD: assert property ($fell(ext_mode) |-> last_op == ffp_pkg::FFP_OP_EXT_EXIT || $past(srst))
    else $error("ext left early");
  AST_WE_FRAME: assert property ($fell(flash_we_n) |-> !flash_ce_n && flash_dq_oe && flash_oe_n ##1 flash_we_n)
    else $error("bad write strobe");
  AST_WE_RECOVER: assert property ($rose(flash_we_n) |-> flash_we_n [*3])
    else $error("write strobe high too short");
  COV_FULL_WBUF: cover property (acc && cmd_op == ffp_pkg::FFP_OP_WBUF && cmd_count == 5'h1f);
  COV_BYPASS: cover property ($rose(bypass_mode));
  COV_EXT: cover property ($rose(ext_mode));
  COV_BYPASS_EBUF: cover property (acc && cmd_op == ffp_pkg::FFP_OP_EBUF && bypass_mode);
endmodule
bind ffp_host ffp_host_checker #(.EBUF_WORDS(EBUF_WORDS)) i_chk (.core_clk, .srst, .cmd_valid, .cmd_op, .cmd_addr,
  .cmd_count, .cmd_ready, .cmd_done, .cmd_error, .bypass_mode, .ext_mode, .flash_dq_oe, .flash_ce_n, .flash_we_n,
  .flash_oe_n);

// >>> verification/ffp_host_bench.sv
/*
 Self-checking bench for the flash command host against the flash model.
 Assumes the model logs writes in order and answers reads at once.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module ffp_host_bench;
  logic             core_clk, srst, cmd_valid, cmd_ready, wd_valid, wd_ready, cmd_done, cmd_error;
  ffp_pkg::ffp_op_t cmd_op;
  logic [22:0]      cmd_addr, flash_addr, a, ea[$];
  logic [15:0]      cmd_data, wd_data, rd_data, flash_dq_out, flash_dq_in, wq[$], ed[$];
  logic [4:0]       cmd_count, c;
  logic             bypass_mode, ext_mode, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, byp, ext;
  bit               ec[$];
  int               n_errors, n_compared, seed;
  ffp_host #(.EBUF_WORDS(256)) i_dut (.core_clk, .srst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_count,
    .cmd_ready, .wd_valid, .wd_data, .wd_ready, .cmd_done, .cmd_error, .rd_data, .bypass_mode, .ext_mode,
    .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_we_n, .flash_oe_n);
  ffp_flash_model i_model (.flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n, .flash_oe_n,
    .flash_dq_in);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic print_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ex(input logic [22:0] ad, input logic [15:0] d, input bit k);
    ea.push_back(ad);
    ed.push_back(d);
    ec.push_back(k);
  endtask
  task automatic unl();
    ex(23'h555, 16'haa, 1'b1);
    ex(23'h2aa, 16'h55, 1'b1);
  endtask
  function automatic logic [15:0] rdv(input logic [22:0] ad);
    return (ext && ad[22:16] == 7'h00) ? {9'h000, ad[6:0]} ^ 16'hc3c3 : ad[15:0] ^ 16'h5a5a;
  endfunction
  task automatic do_cmd(input ffp_pkg::ffp_op_t op, input logic [22:0] ad, input logic [15:0] d, input logic [4:0] n);
    int k;
    int n0;
    logic err;
    err = 1'b0;
    wq.delete();
    ea.delete();
    ed.delete();
    ec.delete();
    n0 = i_model.la.size();
    cmd_op <= op;
    cmd_addr <= ad;
    cmd_data <= d;
    cmd_count <= n;
    cmd_valid <= 1'b1;
    k = 0;
    do begin @(posedge core_clk); k++; end while (cmd_ready !== 1'b1 && k < 50);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
      if (wd_ready === 1'b1) begin
        wq.push_back(wd_data);
        wd_data <= $random(seed);
        wd_valid <= 1'($random(seed));
      end else if (wd_valid !== 1'b1) begin
        // Word stream stalls a few cycles at random
        wd_valid <= (($random(seed) & 7) == 0);
      end
    end while (cmd_done !== 1'b1 && k < 4000);
    `CHK(cmd_done, 1'b1)
    case (op)
      ffp_pkg::FFP_OP_WBUF: begin
        err = {1'b0, ad[4:0]} + {1'b0, n} > 6'd31;
        if (!byp) unl();
        ex(ad, 16'h25, 1'b1);
        ex(ad, {11'h000, n}, 1'b1);
        for (int i = 0; i <= n; i++) ex({ad[22:5], ad[4:0] + 5'(i)}, wq[i], 1'b1);
        ex(ad, 16'h29, 1'b1);
      end
      ffp_pkg::FFP_OP_ABORT: begin unl(); ex(23'h555, 16'hf0, 1'b1); end
      ffp_pkg::FFP_OP_BYPASS_ENTER: begin err = ext; unl(); ex(23'h555, 16'h20, 1'b1); byp = !err; end
      ffp_pkg::FFP_OP_BYPASS_PROG: begin err = !byp; ex(23'h0, 16'ha0, 1'b0); ex(ad, d, 1'b1); end
      ffp_pkg::FFP_OP_BYPASS_BLK_ERASE: begin err = !byp || ext; ex(23'h0, 16'h80, 1'b0); ex(ad, 16'h30, 1'b1); end
      ffp_pkg::FFP_OP_BYPASS_CHIP_ERASE: begin err = !byp || ext; ex(23'h0, 16'h80, 1'b0); ex(23'h0, 16'h10, 1'b0); end
      ffp_pkg::FFP_OP_BYPASS_RESET: begin err = !byp; ex(23'h0, 16'h90, 1'b0); ex(23'h0, 16'h00, 1'b0); byp = 1'b0; end
      ffp_pkg::FFP_OP_EBUF: begin
        if (!byp) unl();
        ex(ad, 16'h33, 1'b1);
        for (int i = 0; i < 256; i++) ex({ad[22:8], 8'(i)}, wq[i], 1'b1);
        ex({ad[22:8], 8'h00}, 16'h29, 1'b1);
      end
      ffp_pkg::FFP_OP_EXT_ENTER: begin unl(); ex(23'h555, 16'h88, 1'b1); ext = 1'b1; end
      ffp_pkg::FFP_OP_EXT_EXIT: begin unl(); ex(23'h555, 16'h90, 1'b1); ex(23'h0, 16'h00, 1'b0); ext = 1'b0; end
      default: ;
    endcase
    `CHK(cmd_error, err)
    if (err) ea.delete();
    @(posedge core_clk);
    `CHK(i_model.la.size() - n0, ea.size())
    foreach (ea[i]) begin
      if (ec[i]) `CHK(i_model.la[n0 + i], ea[i])
      `CHK(i_model.ld[n0 + i], ed[i])
    end
    if (op == ffp_pkg::FFP_OP_READ) `CHK(rd_data, rdv(ad))
    `CHK(bypass_mode, byp)
    `CHK(i_model.byp, byp)
    `CHK(i_model.ext, ext)
    `CHK(ext_mode, ext)
  endtask
  initial begin
    #3000000;
    `CHK(1'b0, 1'b1)
    print_verdict();
  end
  initial begin
    seed = 32'ha1c8f45f;
    n_errors = 0;
    n_compared = 0;
    byp = 1'b0;
    ext = 1'b0;
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = ffp_pkg::FFP_OP_READ;
    cmd_addr = 23'h000000;
    cmd_data = 16'h0000;
    cmd_count = 5'h00;
    wd_valid = 1'b1;
    wd_data = $random(seed);
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    do_cmd(ffp_pkg::FFP_OP_BYPASS_PROG, 23'h000040, 16'h1234, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_WBUF, 23'h010020, 16'h0000, 5'h1f);
    do_cmd(ffp_pkg::FFP_OP_WBUF, 23'h010021, 16'h0000, 5'h1f);
    repeat (6) begin
      c = $random(seed);
      a = $random(seed);
      // Disjoint offset bits keep the load inside one page
      a[4:0] = a[4:0] & ~c;
      do_cmd(ffp_pkg::FFP_OP_WBUF, a, 16'h0000, c);
    end
    do_cmd(ffp_pkg::FFP_OP_ABORT, a, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_EBUF, {a[22:8], 8'h00}, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_BYPASS_ENTER, a, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_WBUF, a, 16'h0000, c);
    do_cmd(ffp_pkg::FFP_OP_BYPASS_PROG, a, $random(seed), 5'h00);
    do_cmd(ffp_pkg::FFP_OP_BYPASS_BLK_ERASE, a, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_BYPASS_BLK_ERASE, a ^ 23'h010000, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_BYPASS_CHIP_ERASE, a, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_EBUF, {a[22:8], 8'h00}, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_BYPASS_RESET, a, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_BYPASS_RESET, a, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_EXT_ENTER, a, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_READ, {7'h00, a[15:0]}, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_BYPASS_ENTER, a, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_BYPASS_BLK_ERASE, a, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_EXT_EXIT, a, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_READ, {7'h00, a[15:0]}, 16'h0000, 5'h00);
    do_cmd(ffp_pkg::FFP_OP_EXT_ENTER, a, 16'h0000, 5'h00);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    `CHK(ext_mode, 1'b0)
    print_verdict();
  end
endmodule
